// ===== logic/lpc_pkg.sv
// Purpose: Shared constants for the light/near sensor serial link.
// Assumes: 100 MHz system clock.
// Notes: Register indices are 5-bit offsets from REG_FIRST.
package lpc_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h13;
	localparam logic [7:0] ADDR_WR = 8'h26;
	localparam logic [7:0] ADDR_RD = 8'h27;
	localparam logic [7:0] REG_FIRST = 8'h80;
	localparam logic [7:0] REG_LAST = 8'h90;
	localparam int REG_COUNT = 17;
	localparam logic [4:0] IDX_CMD = 5'h00;
	localparam logic [4:0] IDX_ID = 5'h01;
	localparam logic [4:0] IDX_NEAR_RATE = 5'h02;
	localparam logic [4:0] IDX_LED = 5'h03;
	localparam logic [4:0] IDX_LIGHT_PARAM = 5'h04;
	localparam logic [4:0] IDX_LIGHT_HI = 5'h05;
	localparam logic [4:0] IDX_LIGHT_LO = 5'h06;
	localparam logic [4:0] IDX_NEAR_HI = 5'h07;
	localparam logic [4:0] IDX_NEAR_LO = 5'h08;
	localparam int CMD_LOCK = 7;
	localparam int CMD_LIGHT_RDY = 6;
	localparam int CMD_NEAR_RDY = 5;
	localparam int CMD_LIGHT_SINGLE = 4;
	localparam int CMD_NEAR_SINGLE = 3;
	localparam int CMD_LIGHT_EN = 2;
	localparam int CMD_NEAR_EN = 1;
	localparam int CMD_SELFTIMED = 0;
	localparam int NEAR_RATE_LSB = 0;
	localparam int LIGHT_RATE_LSB = 4;
	localparam logic [7:0] LED_RESET = 8'h02;
	localparam logic [7:0] ID_VALUE = 8'h5A; // Arbitrary identity value
	localparam logic [7:0] HOST_OFF_REG = 8'h00;
	localparam logic [7:0] HOST_OFF_WDATA = 8'h01;
	localparam logic [7:0] HOST_OFF_CTRL = 8'h02;
	localparam logic [7:0] HOST_OFF_STAT = 8'h03;
	localparam logic [7:0] HOST_OFF_RDATA = 8'h04;
	localparam int CTRL_GO_WR = 0;
	localparam int CTRL_GO_RD = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_DONE = 2;
	localparam int CLK_NS = 10;
	localparam int QUARTER_NS = 2500;
	localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
	localparam int LP_TICK_US = 4000;
	localparam int LP_TICK_CYCLES = LP_TICK_US * 1000 / CLK_NS;
	localparam int CONV_CYCLES = 1000;
endpackage

// ===== logic/lpc_link_if.sv
// Purpose: Two-wire link between host controller and sensor target.
// Assumes: Open-drain lines with pull-ups.
// Notes: Line levels resolved here from the enables.
`timescale 1ns/100ps
interface lpc_link_if;
	logic scl_o_h;
	logic scl_oe_h;
	logic sda_o_h;
	logic sda_oe_h;
	logic sda_o_d;
	logic sda_oe_d;
	logic scl_line;
	logic sda_line;
	assign scl_line = ~(scl_oe_h & ~scl_o_h);
	assign sda_line = ~((sda_oe_h & ~sda_o_h) | (sda_oe_d & ~sda_o_d));
	modport host (output scl_o_h, output scl_oe_h, output sda_o_h, output sda_oe_h, input scl_line, input sda_line);
	modport dev (output sda_o_d, output sda_oe_d, input scl_line, input sda_line);
endinterface

// ===== logic/lpc_dev.sv
// Purpose: Sensor serial target, register file and measurement sequencer.
// Assumes: Link lines sampled by i_clock; no clock stretching.
`timescale 1ns/100ps
module lpc_dev
	import lpc_pkg::*;
#(
	parameter int LP_TICK = LP_TICK_CYCLES,
	parameter int CONV = CONV_CYCLES
)(
	input wire logic i_clock,
	input wire logic i_rst,
	lpc_link_if.dev link,
	input wire logic [15:0] i_light_value,
	input wire logic [15:0] i_near_value,
	output logic o_light_start,
	output logic o_near_start
);
	typedef enum logic [4:0] {
		D_IDLE = 5'b00001,
		D_RX = 5'b00010,
		D_ACK = 5'b00100,
		D_TX = 5'b01000,
		D_TXACK = 5'b10000
	} lpc_dstate_t;

	function automatic logic [7:0] rate_period(input logic [2:0] r);
		return 8'h80 >> r;
	endfunction

	lpc_dstate_t state_ff;
	logic [2:0] scl_sync_ff, sda_sync_ff;
	logic scl_ff, sda_ff, scl_upd, sda_upd, scl_rise, scl_fall, start_det, stop_det;
	logic [3:0] bit_ff;
	logic [1:0] byte_ff;
	logic [7:0] shift_ff, ptr_ff, rd_byte;
	logic rw_ff, nack_ff, sda_oe_ff, sda_o_ff;
	logic take_byte, wr_pulse, rd_pulse, ptr_ok;
	logic [4:0] idx;
	logic [7:0] regs_ff [0:REG_COUNT-1];
	logic st_ff, st_prev_ff, light_en_ff, near_en_ff, light_single_ff, near_single_ff;
	logic light_rdy_ff, near_rdy_ff, cmd_wr, single_go;
	logic [15:0] light_res_ff, near_res_ff;
	logic [1:0] busy_ff, start_ff, done, req, per_en;
	logic [31:0] conv_ff [0:1];
	logic [7:0] per_ff [0:1];
	logic [2:0] rate_ff [0:1];
	logic [31:0] lp_ff;
	logic lp_tick;

	// Three-stage sampling, change accepted when stages two and three agree
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[1:0], link.scl_line};
			sda_sync_ff <= {sda_sync_ff[1:0], link.sda_line};
			scl_ff <= scl_upd;
			sda_ff <= sda_upd;
		end
	end
	assign scl_upd = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_ff;
	assign sda_upd = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
	assign scl_rise = ~scl_ff & scl_upd;
	assign scl_fall = scl_ff & ~scl_upd;
	assign start_det = scl_ff & scl_upd & sda_ff & ~sda_upd;
	assign stop_det = scl_ff & scl_upd & ~sda_ff & sda_upd;

	assign idx = 5'(ptr_ff - REG_FIRST);
	assign ptr_ok = (ptr_ff >= REG_FIRST) && (ptr_ff <= REG_LAST);
	assign take_byte = (state_ff == D_RX) && scl_fall && (bit_ff == 4'd8);
	assign wr_pulse = take_byte && (byte_ff == 2'd2) && ptr_ok;
	assign rd_pulse = scl_fall && ptr_ok && (((state_ff == D_ACK) && rw_ff) || ((state_ff == D_TXACK) && !nack_ff));
	assign cmd_wr = wr_pulse && (idx == IDX_CMD);

	// Edge-driven target sequence; levels only move on falling clock
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_ff <= D_IDLE;
			bit_ff <= 4'h0;
			byte_ff <= 2'h0;
			shift_ff <= 8'h00;
			ptr_ff <= REG_FIRST;
			rw_ff <= 1'b0;
			nack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end
		else if (start_det)
		begin
			state_ff <= D_RX;
			bit_ff <= 4'h0;
			byte_ff <= 2'h0;
			sda_oe_ff <= 1'b0;
		end
		else if (stop_det)
		begin
			state_ff <= D_IDLE;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			unique case (state_ff)
				D_IDLE:
					sda_oe_ff <= 1'b0;
				D_RX:
				begin
					if (scl_rise && bit_ff != 4'd8)
					begin
						shift_ff <= {shift_ff[6:0], sda_upd};
						bit_ff <= bit_ff + 4'd1;
					end
					if (take_byte)
					begin
						if (byte_ff != 2'd2)
							byte_ff <= byte_ff + 2'd1;
						if (byte_ff == 2'd0)
						begin
							if (shift_ff[7:1] == DEV_ADDR)
							begin
								rw_ff <= shift_ff[0];
								sda_oe_ff <= 1'b1;
								state_ff <= D_ACK;
							end
							else
								state_ff <= D_IDLE;
						end
						else
						begin
							if (byte_ff == 2'd1)
								ptr_ff <= shift_ff;
							else
								ptr_ff <= ptr_ff + 8'h01;
							sda_oe_ff <= 1'b1;
							state_ff <= D_ACK;
						end
					end
				end
				D_ACK:
					if (scl_fall)
					begin
						if (rw_ff)
						begin
							shift_ff <= rd_byte;
							sda_oe_ff <= ~rd_byte[7];
							bit_ff <= 4'd1;
							ptr_ff <= ptr_ff + 8'h01;
							state_ff <= D_TX;
						end
						else
						begin
							sda_oe_ff <= 1'b0;
							bit_ff <= 4'h0;
							state_ff <= D_RX;
						end
					end
				D_TX:
					if (scl_fall)
					begin
						if (bit_ff == 4'd8)
						begin
							sda_oe_ff <= 1'b0;
							state_ff <= D_TXACK;
						end
						else
						begin
							sda_oe_ff <= ~shift_ff[6];
							shift_ff <= {shift_ff[6:0], 1'b0};
							bit_ff <= bit_ff + 4'd1;
						end
					end
				D_TXACK:
				begin
					if (scl_rise)
						nack_ff <= sda_upd;
					if (scl_fall)
					begin
						if (!nack_ff)
						begin
							shift_ff <= rd_byte;
							sda_oe_ff <= ~rd_byte[7];
							bit_ff <= 4'd1;
							ptr_ff <= ptr_ff + 8'h01;
							state_ff <= D_TX;
						end
						else
							state_ff <= D_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		sda_o_ff <= 1'b0;
	end
	assign link.sda_oe_d = sda_oe_ff;
	assign link.sda_o_d = sda_o_ff;

	// Plain read/write registers
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < REG_COUNT; i++)
				regs_ff[i] <= 8'h00;
			regs_ff[IDX_LED] <= LED_RESET;
		end
		else if (wr_pulse && idx != IDX_CMD && idx != IDX_ID && (idx < IDX_LIGHT_HI || idx > IDX_NEAR_LO))
			regs_ff[idx] <= shift_ff;
	end

	always_comb
	begin
		rd_byte = regs_ff[idx];
		unique case (idx)
			IDX_CMD: rd_byte = {1'b1, light_rdy_ff, near_rdy_ff, light_single_ff, near_single_ff,
				light_en_ff, near_en_ff, st_ff};
			IDX_ID: rd_byte = ID_VALUE;
			IDX_LIGHT_HI: rd_byte = light_res_ff[15:8];
			IDX_LIGHT_LO: rd_byte = light_res_ff[7:0];
			IDX_NEAR_HI: rd_byte = near_res_ff[15:8];
			IDX_NEAR_LO: rd_byte = near_res_ff[7:0];
			default: rd_byte = regs_ff[idx];
		endcase
		if (!ptr_ok)
			rd_byte = 8'h00;
	end

	// Command register; hardware (done) wins over software set or clear
	assign single_go = cmd_wr && !st_ff && !shift_ff[CMD_SELFTIMED];
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			st_ff <= 1'b0;
			st_prev_ff <= 1'b0;
			light_en_ff <= 1'b0;
			near_en_ff <= 1'b0;
			light_single_ff <= 1'b0;
			near_single_ff <= 1'b0;
			light_rdy_ff <= 1'b0;
			near_rdy_ff <= 1'b0;
		end
		else
		begin
			st_prev_ff <= st_ff;
			if (cmd_wr)
			begin
				st_ff <= shift_ff[CMD_SELFTIMED];
				light_en_ff <= shift_ff[CMD_LIGHT_EN];
				near_en_ff <= shift_ff[CMD_NEAR_EN];
			end
			if (done[0])
				light_single_ff <= 1'b0;
			else if (single_go && shift_ff[CMD_LIGHT_SINGLE])
				light_single_ff <= 1'b1;
			if (done[1])
				near_single_ff <= 1'b0;
			else if (single_go && shift_ff[CMD_NEAR_SINGLE])
				near_single_ff <= 1'b1;
			if (done[0])
				light_rdy_ff <= 1'b1;
			else if (rd_pulse && (idx == IDX_LIGHT_HI || idx == IDX_LIGHT_LO))
				light_rdy_ff <= 1'b0;
			if (done[1])
				near_rdy_ff <= 1'b1;
			else if (rd_pulse && (idx == IDX_NEAR_HI || idx == IDX_NEAR_LO))
				near_rdy_ff <= 1'b0;
		end
	end

	// Slow oscillator runs only while self-timed mode is on
	assign lp_tick = st_ff && (lp_ff == 32'(LP_TICK - 1));
	always_ff @(posedge i_clock)
	begin
		if (i_rst || !st_ff)
			lp_ff <= 32'h0000_0000;
		else if (lp_tick)
			lp_ff <= 32'h0000_0000;
		else
			lp_ff <= lp_ff + 32'h0000_0001;
	end

	// Channel 0 light, channel 1 near
	assign per_en = {near_en_ff, light_en_ff} & {2{st_ff}};
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			done[c] = busy_ff[c] && (conv_ff[c] == 32'h0000_0000);
			req[c] = lp_tick && per_en[c] && (per_ff[c] == 8'h00);
		end
		req[0] = req[0] | (single_go && shift_ff[CMD_LIGHT_SINGLE]);
		req[1] = req[1] | (single_go && shift_ff[CMD_NEAR_SINGLE]);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			busy_ff <= 2'b00;
			start_ff <= 2'b00;
			for (int c = 0; c < 2; c++)
			begin
				conv_ff[c] <= 32'h0000_0000;
				per_ff[c] <= 8'h00;
				rate_ff[c] <= 3'h0;
			end
		end
		else
		begin
			start_ff <= req & ~busy_ff;
			if (st_ff && !st_prev_ff)
			begin
				rate_ff[0] <= regs_ff[IDX_LIGHT_PARAM][LIGHT_RATE_LSB +: 3];
				rate_ff[1] <= regs_ff[IDX_NEAR_RATE][NEAR_RATE_LSB +: 3];
			end
			for (int c = 0; c < 2; c++)
			begin
				if (!st_ff)
					per_ff[c] <= 8'h00;
				else if (lp_tick && per_en[c])
					per_ff[c] <= (per_ff[c] == 8'h00) ? rate_period(rate_ff[c]) - 8'h01 : per_ff[c] - 8'h01;
				if (req[c] && !busy_ff[c])
				begin
					busy_ff[c] <= 1'b1;
					conv_ff[c] <= 32'(CONV - 1);
				end
				else if (done[c])
					busy_ff[c] <= 1'b0;
				else if (busy_ff[c])
					conv_ff[c] <= conv_ff[c] - 32'h0000_0001;
			end
		end
	end

	// Results latched at end of conversion, both bytes in the same cycle
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			light_res_ff <= 16'h0000;
			near_res_ff <= 16'h0000;
		end
		else
		begin
			if (done[0])
				light_res_ff <= i_light_value;
			if (done[1])
				near_res_ff <= i_near_value;
		end
	end

	assign o_light_start = start_ff[0];
	assign o_near_start = start_ff[1];
endmodule

// ===== logic/lpc_host.sv
// Purpose: Two-wire controller issuing register writes and reads to the sensor.
// Assumes: Software port with one-cycle strobes; host makes the link clock.
// Notes: One byte per transfer.
`timescale 1ns/100ps
module lpc_host
	import lpc_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYCLES
)(
	input wire logic i_clock,
	input wire logic i_rst,
	lpc_link_if.host link,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b01,
		H_RUN = 2'b10
	} lpc_hstate_t;
	typedef enum logic [1:0] {
		OP_START,
		OP_TX,
		OP_RX,
		OP_STOP
	} lpc_op_t;

	lpc_hstate_t state_ff;
	logic [7:0] reg_ff, wdata_ff, rdata_ff, sh_ff, o_rdata_ff;
	logic busy_ff, nack_ff, done_ff, rd_mode_ff, scl_oe_ff, sda_oe_ff, zero_ff;
	logic [2:0] step_ff, sda_sync_ff;
	logic [1:0] q_ff;
	logic [3:0] bit_ff;
	logic [31:0] div_ff;
	logic sda_ff, sda_upd, qtick, go, fin;
	lpc_op_t op;
	logic [7:0] cur_byte;

	// Step table for write and read sequences
	always_comb
	begin
		op = OP_TX;
		cur_byte = ADDR_WR;
		unique case (step_ff)
			3'd0: op = OP_START;
			3'd1: cur_byte = ADDR_WR;
			3'd2: cur_byte = reg_ff;
			3'd3:
			begin
				op = rd_mode_ff ? OP_START : OP_TX;
				cur_byte = wdata_ff;
			end
			3'd4:
			begin
				op = rd_mode_ff ? OP_TX : OP_STOP;
				cur_byte = ADDR_RD;
			end
			3'd5: op = OP_RX;
			default: op = OP_STOP;
		endcase
	end

	assign sda_upd = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
	assign qtick = (state_ff == H_RUN) && (div_ff == 32'(QUARTER - 1));
	assign go = i_wr && (i_addr == HOST_OFF_CTRL) && !busy_ff && (i_wdata[CTRL_GO_WR] || i_wdata[CTRL_GO_RD]);
	assign fin = qtick && (op == OP_STOP) && (q_ff == 2'd3);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			sda_sync_ff <= 3'h7;
			sda_ff <= 1'b1;
			div_ff <= 32'h0000_0000;
		end
		else
		begin
			sda_sync_ff <= {sda_sync_ff[1:0], link.sda_line};
			sda_ff <= sda_upd;
			div_ff <= (qtick || state_ff == H_IDLE) ? 32'h0000_0000 : div_ff + 32'h0000_0001;
		end
	end

	// Quarter-phase sequencer; data moves while the clock is low, except the start and stop edges in quarter 3
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_ff <= H_IDLE;
			step_ff <= 3'd0;
			q_ff <= 2'd0;
			bit_ff <= 4'd0;
			sh_ff <= 8'h00;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			nack_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
		end
		else if (state_ff == H_IDLE)
		begin
			if (go)
			begin
				state_ff <= H_RUN;
				rd_mode_ff <= i_wdata[CTRL_GO_RD];
				nack_ff <= 1'b0;
				step_ff <= 3'd0;
				q_ff <= 2'd0;
				bit_ff <= 4'd0;
			end
		end
		else if (qtick)
		begin
			q_ff <= q_ff + 2'd1;
			unique case (q_ff)
				2'd0: scl_oe_ff <= 1'b1;
				2'd1:
					unique case (op)
						OP_START: sda_oe_ff <= 1'b0;
						OP_STOP: sda_oe_ff <= 1'b1;
						OP_TX: sda_oe_ff <= (bit_ff == 4'd8) ? 1'b0 : ~cur_byte[3'(4'd7 - bit_ff)];
						OP_RX: sda_oe_ff <= 1'b0;
					endcase
				2'd2: scl_oe_ff <= 1'b0;
				2'd3:
					unique case (op)
						OP_START:
						begin
							sda_oe_ff <= 1'b1;
							step_ff <= step_ff + 3'd1;
						end
						OP_STOP:
						begin
							sda_oe_ff <= 1'b0;
							state_ff <= H_IDLE;
						end
						default:
						begin
							if (bit_ff != 4'd8)
							begin
								sh_ff <= {sh_ff[6:0], sda_upd};
								bit_ff <= bit_ff + 4'd1;
							end
							else
							begin
								bit_ff <= 4'd0;
								if (op == OP_TX && sda_upd)
								begin
									nack_ff <= 1'b1;
									step_ff <= rd_mode_ff ? 3'd6 : 3'd4;
								end
								else
									step_ff <= step_ff + 3'd1;
							end
						end
					endcase
			endcase
		end
	end

	// Software-facing status and read port
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			reg_ff <= REG_FIRST;
			wdata_ff <= 8'h00;
			rdata_ff <= 8'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			o_rdata_ff <= 8'h00;
			zero_ff <= 1'b0;
		end
		else
		begin
			zero_ff <= 1'b0;
			if (i_wr && !busy_ff && i_addr == HOST_OFF_REG)
				reg_ff <= i_wdata;
			if (i_wr && !busy_ff && i_addr == HOST_OFF_WDATA)
				wdata_ff <= i_wdata;
			if (go)
				busy_ff <= 1'b1;
			else if (fin)
				busy_ff <= 1'b0;
			if (fin && rd_mode_ff && !nack_ff)
				rdata_ff <= sh_ff;
			if (fin)
				done_ff <= 1'b1;
			else if ((i_rd && i_addr == HOST_OFF_STAT) || go)
				done_ff <= 1'b0;
			o_rdata_ff <= 8'h00;
			if (i_rd)
				unique case (i_addr)
					HOST_OFF_REG: o_rdata_ff <= reg_ff;
					HOST_OFF_WDATA: o_rdata_ff <= wdata_ff;
					HOST_OFF_STAT: o_rdata_ff <= {5'h00, done_ff, nack_ff, busy_ff};
					HOST_OFF_RDATA: o_rdata_ff <= rdata_ff;
					default: o_rdata_ff <= 8'h00;
				endcase
		end
	end

	assign link.scl_oe_h = scl_oe_ff;
	assign link.sda_oe_h = sda_oe_ff;
	assign link.scl_o_h = zero_ff;
	assign link.sda_o_h = zero_ff;
	assign o_rdata = o_rdata_ff;
endmodule

// ===== tb/lpc_link_properties.sv
// Purpose: Checks on the link between host and sensor ends.
// Assumes: Host quarter of 8 cycles.
// Notes: Watches resolved lines, enables and start pulses.
`timescale 1ns/100ps
module lpc_link_props
	import lpc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic scl_o_h,
	input wire logic scl_oe_h,
	input wire logic sda_o_d,
	input wire logic sda_oe_d,
	input wire logic scl_line,
	input wire logic sda_line,
	input wire logic o_light_start,
	input wire logic o_near_start
);
	logic scl_ff;
	logic sda_ff;
	logic first_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff;
	logic start;
	logic rise;
	logic ack9;
	assign start = scl_line & scl_ff & sda_ff & ~sda_line;
	assign rise = scl_line & ~scl_ff;
	assign ack9 = rise & (bit_ff == 4'h8) & first_ff;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	// Previous line levels
	always_ff @(posedge i_clock)
	begin
		scl_ff <= i_rst | scl_line;
		sda_ff <= i_rst | sda_line;
	end
	// Bit position in the current byte
	always_ff @(posedge i_clock)
	begin
		if (i_rst | start)
		begin
			bit_ff <= 4'h0;
			first_ff <= ~i_rst;
		end
		else if (rise & (bit_ff == 4'h8))
		begin
			bit_ff <= 4'h0;
			first_ff <= 1'b0;
		end
		else if (rise)
			bit_ff <= bit_ff + 4'h1;
	end
	// Bits seen on the line
	always_ff @(posedge i_clock)
	begin
		if (rise)
			shift_ff <= {shift_ff[6:0], sda_line};
	end
	scl_drive_zero_a: assert property (scl_oe_h |-> !scl_o_h)
		else $error("host drives clock high");
	sda_drive_zero_a: assert property (sda_oe_d |-> !sda_o_d)
		else $error("device drives data high");
	sda_edge_low_a: assert property (scl_line && scl_ff |-> $stable(sda_oe_d))
		else $error("device changed data while clock high");
	scl_high_time_a: assert property ($rose(scl_line) |-> scl_line [*8])
		else $error("clock high phase too short");
	scl_low_time_a: assert property ($fell(scl_line) |-> !scl_line [*8])
		else $error("clock low phase too short");
	addr_byte_a: assert property (ack9 |-> shift_ff == ADDR_WR || shift_ff == ADDR_RD)
		else $error("address byte wrong");
	addr_ack_a: assert property (ack9 |-> !sda_line && sda_oe_d)
		else $error("address byte not acknowledged");
	start_free_a: assert property (start |-> !sda_oe_d)
		else $error("device holds data at start");
	idle_reset_a: assert property ($fell(i_rst) |-> scl_line && sda_line)
		else $error("lines not idle after reset");
	light_pulse_a: assert property (o_light_start |=> !o_light_start)
		else $error("light start longer than one cycle");
	near_pulse_a: assert property (o_near_start |=> !o_near_start)
		else $error("near start longer than one cycle");
endmodule

// ===== tb/light_prox_i2c_command_ctrl_tb.sv
// Purpose: Host and sensor ends joined, driven from the software port.
// Assumes: Short quarter, tick and conversion counts.
// Notes: Register cases from a table, then measurement cases.
`timescale 1ns/100ps
module light_prox_i2c_command_ctrl_tb
	import lpc_pkg::*;
;
	typedef struct packed {logic wr; logic [7:0] r; logic [7:0] d;} lpc_row_t;
	logic i_clock = 1'b0;
	logic i_rst;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [7:0] o_rdata;
	logic [15:0] light_val;
	logic [15:0] near_val;
	logic o_light_start;
	logic o_near_start;
	logic [7:0] q;
	int miscompares = 0;
	int total_checks = 0;
	int nl = 0;
	int nn = 0;
	int nb = 0;
	int b0;
	int c0;
	int d0;
	lpc_row_t rows [16] = '{'{1'b0, 8'h80, 8'h80}, '{1'b0, 8'h81, ID_VALUE}, '{1'b0, 8'h83, LED_RESET},
		'{1'b1, 8'h83, 8'h0a}, '{1'b0, 8'h83, 8'h0a}, '{1'b1, 8'h82, 8'h03}, '{1'b0, 8'h82, 8'h03},
		'{1'b1, 8'h84, 8'h30}, '{1'b0, 8'h84, 8'h30}, '{1'b1, 8'h90, 8'ha5}, '{1'b0, 8'h90, 8'ha5},
		'{1'b1, 8'h91, 8'h77}, '{1'b0, 8'h91, 8'h00}, '{1'b0, 8'h7f, 8'h00}, '{1'b1, 8'h80, 8'h00},
		'{1'b0, 8'h80, 8'h80}};
	lpc_link_if link();
	lpc_host #(.QUARTER(8)) i_lpc_host(.i_clock(i_clock), .i_rst(i_rst), .link(link), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
	lpc_dev #(.LP_TICK(50), .CONV(10)) i_lpc_dev(.i_clock(i_clock), .i_rst(i_rst), .link(link),
		.i_light_value(light_val), .i_near_value(near_val), .o_light_start(o_light_start),
		.o_near_start(o_near_start));
	lpc_link_props i_lpc_link_props(.i_clock(i_clock), .i_rst(i_rst), .scl_o_h(link.scl_o_h),
		.scl_oe_h(link.scl_oe_h), .sda_o_d(link.sda_o_d), .sda_oe_d(link.sda_oe_d),
		.scl_line(link.scl_line), .sda_line(link.sda_line), .o_light_start(o_light_start),
		.o_near_start(o_near_start));
	always #5 i_clock = ~i_clock;
	// Count start pulses
	always @(posedge i_clock)
	begin
		if (o_light_start === 1'b1)
			nl <= nl + 1;
		if (o_near_start === 1'b1)
			nn <= nn + 1;
		if (o_light_start === 1'b1 && o_near_start === 1'b1)
			nb <= nb + 1;
	end
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task sw_wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		@(posedge i_clock);
	endtask
	task sw_rd(input logic [7:0] a, output logic [7:0] d);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		@(posedge i_clock);
	endtask
	task xfer(input logic [7:0] r, input logic [7:0] d, input logic rd, output logic [7:0] v);
		logic [7:0] s;
		int k;
		sw_wr(HOST_OFF_REG, r);
		sw_wr(HOST_OFF_WDATA, d);
		sw_wr(HOST_OFF_CTRL, rd ? 8'h02 : 8'h01);
		s = 8'h00;
		for (k = 0; k < 2000 && s[STAT_DONE] !== 1'b1; k++)
			sw_rd(HOST_OFF_STAT, s);
		if (s[STAT_DONE] !== 1'b1)
		begin
			miscompares++;
			$display("[ERR] %0t transfer timeout", $time);
			finish_test();
		end
		chk(8'(s[STAT_NACK]), 8'h00);
		sw_rd(HOST_OFF_RDATA, v);
	endtask
	task reg_wr(input logic [7:0] r, input logic [7:0] d);
		logic [7:0] v;
		xfer(r, d, 1'b0, v);
	endtask
	task reg_chk(input logic [7:0] r, input logic [7:0] e);
		logic [7:0] v;
		xfer(r, 8'h00, 1'b1, v);
		chk(v, e);
	endtask
	initial
	begin
		i_rst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		light_val = 16'habcd;
		near_val = 16'h1234;
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		foreach (rows[i])
			if (rows[i].wr)
				reg_wr(rows[i].r, rows[i].d);
			else
				reg_chk(rows[i].r, rows[i].d);
		sw_rd(8'h07, q);
		chk(q, 8'h00);
		// Single near request
		b0 = nl;
		c0 = nn;
		reg_wr(8'h80, 8'h08);
		chk(8'(nn - c0), 8'h01);
		chk(8'(nl - b0), 8'h00);
		reg_chk(8'h80, 8'ha0);
		reg_chk(8'h87, 8'h12);
		reg_chk(8'h80, 8'h80);
		reg_chk(8'h88, 8'h34);
		// Both single requests together
		d0 = nb;
		reg_wr(8'h80, 8'h18);
		chk(8'(nb - d0), 8'h01);
		reg_chk(8'h80, 8'he0);
		reg_chk(8'h85, 8'hab);
		reg_chk(8'h80, 8'ha0);
		reg_chk(8'h86, 8'hcd);
		reg_chk(8'h88, 8'h34);
		reg_chk(8'h80, 8'h80);
		// Self-timed mode
		reg_wr(8'h80, 8'h01);
		b0 = nl;
		c0 = nn;
		reg_wr(8'h80, 8'h09);
		repeat (3000) @(posedge i_clock);
		chk(8'(nn - c0 + nl - b0), 8'h00);
		reg_wr(8'h80, 8'h03);
		repeat (2000) @(posedge i_clock);
		chk(8'(nn - c0 >= 2), 8'h01);
		chk(8'(nl - b0), 8'h00);
		reg_chk(8'h80, 8'ha3);
		// Rate change while self-timed waits for a mode recycle
		c0 = nn;
		reg_wr(8'h82, 8'h07);
		repeat (2000) @(posedge i_clock);
		chk(8'(nn - c0 <= 4), 8'h01);
		reg_wr(8'h80, 8'h00);
		c0 = nn;
		reg_wr(8'h80, 8'h03);
		repeat (1000) @(posedge i_clock);
		chk(8'(nn - c0 >= 10), 8'h01);
		b0 = nl;
		reg_wr(8'h80, 8'h05);
		repeat (2000) @(posedge i_clock);
		chk(8'(nl - b0 >= 2), 8'h01);
		reg_wr(8'h80, 8'h00);
		// Reset in mid-run
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		reg_chk(8'h80, 8'h80);
		reg_chk(8'h83, LED_RESET);
		finish_test();
	end
endmodule
